/* common/dtsc_pkg.sv */
package dtsc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  DTSC_PARAMS_OFS   = 8'h58;
  localparam logic [7:0]  DTSC_CMD_OFS      = 8'h50;
  localparam logic [7:0]  DTSC_STATUS_OFS   = 8'h54;
  localparam logic [31:0] DTSC_PARAMS_RST   = 32'h001E_0000;
  localparam logic [31:0] DTSC_CMD_RST      = 32'h0000_0000;
  localparam int          DTSC_CMD_WO_MASKB = 0;

  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int DTSC_STOP_FAIL_BIT   = 8;
  localparam int DTSC_RESTART_INH_BIT = 9;
  localparam int DTSC_RESET_CMD_BIT   = 18;
  localparam int DTSC_MASK_LO         = 11;
  localparam int DTSC_RANK_LO         = 5;
  localparam int DTSC_NEXT_LO         = 2;
  localparam int DTSC_MANUAL_BIT      = 1;
  localparam int DTSC_LAUNCH_BIT      = 0;
  localparam int DTSC_SKIP3T_BIT      = 26;
  localparam int DTSC_SKIPAI_BIT      = 25;
  localparam int DTSC_THREE_BIT       = 24;
  localparam int DTSC_SQUAD_BIT       = 23;
  localparam int DTSC_QUAD_BIT        = 22;
  localparam int DTSC_WSGAP_LO        = 17;
  localparam int DTSC_WLGAP_BIT       = 16;
  localparam int DTSC_REGDIMM_BIT     = 15;
  localparam int DTSC_STEPEXP_LO      = 10;
  localparam int DTSC_CKEEXP_LO       = 5;
  localparam int DTSC_RSTEXP_LO       = 0;
  localparam logic [5:0] DTSC_WL_GAP_SHORT = 6'h10;
  localparam logic [5:0] DTSC_WL_GAP_LONG  = 6'h20;

  // ----------------------------------------
  // training step codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    DTSC_ST_IDLE  = 3'h0,
    DTSC_ST_RDDQS = 3'h1,
    DTSC_ST_RECEIVE_ENABLE = 3'h2,
    DTSC_ST_WRLVL = 3'h3,
    DTSC_ST_WRDQS = 3'h4
  } dtsc_step_t;

  typedef enum logic [2:0] {
    DTSC_RS_IDLE = 3'b001,
    DTSC_RS_RST  = 3'b010,
    DTSC_RS_CKE  = 3'b100
  } dtsc_rst_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dtsc_bus_req_t;

  typedef struct packed {
    logic [2:0] rank;
    logic       regdimm;
    logic       use_three_cycle;
    logic       use_inversion;
    logic [5:0] wl_gap;
    logic [4:0] ws_gap;
  } dtsc_phy_cfg_t;

endpackage : dtsc_pkg

/* core/dtsc_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module dtsc_ctrl
  import dtsc_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire dtsc_bus_req_t bus_req,
  output logic [31:0]        bus_rdata,
  input  wire logic          step_pass,
  input  wire logic          step_done,
  input  wire logic          mrs_request,
  output dtsc_step_t         phy_step,
  output dtsc_phy_cfg_t      phy_cfg,
  output logic               step_start,
  output logic               mrs_go,
  output logic               module_reset_n,
  output logic               cke_allowed
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0]     params_reg;
  logic [31:0]     cmd_reg;
  logic [3:0]      pass_reg;
  logic            done_reg;
  logic            halted_reg;
  dtsc_step_t      step_reg;
  dtsc_rst_state_t rs_reg;
  logic [31:0]     rdata_reg;
  logic            start_reg;
  logic            rstn_out_reg;
  logic            cke_reg;

  wire wr_params = bus_req.wr && (bus_req.addr == DTSC_PARAMS_OFS);
  wire wr_cmd    = bus_req.wr && (bus_req.addr == DTSC_CMD_OFS);
  wire launch    = wr_cmd && bus_req.wdata[DTSC_LAUNCH_BIT];
  wire rst_cmd   = wr_cmd && bus_req.wdata[DTSC_RESET_CMD_BIT];
  // a launch or a manual step acts on the word being written, not the stale one
  wire [31:0] cmd_in  = {13'h0, bus_req.wdata[18:1], 1'b0};
  wire [31:0] cmd_now = wr_cmd ? cmd_in : cmd_reg;
  wire manual    = cmd_now[DTSC_MANUAL_BIT];
  wire stop_fail = cmd_reg[DTSC_STOP_FAIL_BIT] && !cmd_reg[DTSC_RESTART_INH_BIT];
  wire [3:0] skip_mask = cmd_now[DTSC_MASK_LO +: 4];
  wire [2:0] wr_next  = bus_req.wdata[DTSC_NEXT_LO +: 3];

  // ----------------------------------------
  // step timer and module reset timer
  // ----------------------------------------
  logic step_tmo;
  logic rst_tmo;
  // expiry counts only while a step runs; a stale expiry in the load cycle is ignored
  wire  step_exp  = step_tmo && !start_reg && (step_reg != DTSC_ST_IDLE);
  wire  step_load = start_reg || step_exp;
  wire  rs_load   = rst_cmd || (rs_reg == DTSC_RS_RST && rst_tmo);
  // a reset command always starts from the reset width
  wire [4:0] rs_exp = rst_cmd ? params_reg[DTSC_RSTEXP_LO +: 5]
                              : params_reg[DTSC_CKEEXP_LO +: 5];

  dtsc_pow2_timer u_step_timer (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .load    (step_load),
    .exp_n   (params_reg[DTSC_STEPEXP_LO +: 5]),
    .expired (step_tmo)
  );

  dtsc_pow2_timer u_rst_timer (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .load    (rs_load),
    .exp_n   (rs_exp),
    .expired (rst_tmo)
  );

  // ----------------------------------------
  // next enabled step in ascending order
  // ----------------------------------------
  function automatic dtsc_step_t next_step(input logic [2:0] cur, input logic [3:0] msk);
    dtsc_step_t r;
    r = DTSC_ST_IDLE;
    for (int i = 4; i >= 1; i--) begin
      if (i > cur && !msk[i-1]) begin
        r = dtsc_step_t'(i[2:0]);
      end
    end
    return r;
  endfunction : next_step

  // mask bits sit per code: bit 11 receive_enable, 12 rd dqs, 13 wrlvl, 14 wr dqs
  wire [3:0] code_mask = {skip_mask[3], skip_mask[2], skip_mask[0], skip_mask[1]};
  wire       step_end  = step_done || step_exp;
  wire       advance   = !manual && (step_reg != DTSC_ST_IDLE) && !halted_reg && step_end;
  wire       halt_now  = step_exp && !step_done && stop_fail && !halted_reg;
  wire dtsc_step_t adv_step = next_step(step_reg, code_mask);
  // codes above the last step are refused and park the machine in idle
  wire       man_ok    = (wr_next <= 3'h4);
  wire dtsc_step_t man_step = man_ok ? dtsc_step_t'(wr_next) : DTSC_ST_IDLE;

  // ----------------------------------------
  // training step machine
  // ----------------------------------------
  dtsc_step_t step_next;
  always_comb begin
    step_next = step_reg;
    if (launch) begin
      step_next = manual ? man_step : next_step(3'h0, code_mask);
    end else if (wr_cmd && manual) begin
      step_next = man_step;
    end else if (halt_now && !manual) begin
      step_next = step_reg;
    end else if (advance) begin
      step_next = adv_step;
    end
  end

  wire pass_mark = step_done && step_pass && (step_reg != DTSC_ST_IDLE);
  wire seq_end   = (advance && adv_step == DTSC_ST_IDLE && !halt_now)
                || (halt_now && !manual);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      step_reg   <= DTSC_ST_IDLE;
      halted_reg <= 1'b0;
      start_reg  <= 1'b0;
    end else begin
      step_reg   <= step_next;
      start_reg  <= (step_next != step_reg) && (step_next != DTSC_ST_IDLE);
      halted_reg <= launch ? 1'b0 : (halted_reg || (halt_now && !manual));
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // set wins over the launch clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
      pass_reg <= 4'h0;
    end else begin
      done_reg <= seq_end || (done_reg && !launch);
      for (int k = 0; k < 4; k++) begin
        pass_reg[k] <= (pass_mark && step_reg == dtsc_step_t'(3'(k + 1)))
                    || (pass_reg[k] && !launch);
      end
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      params_reg <= DTSC_PARAMS_RST;
      cmd_reg    <= DTSC_CMD_RST;
    end else begin
      if (wr_params) begin
        params_reg <= {5'h0, bus_req.wdata[26:0]};
      end
      if (wr_cmd) begin
        cmd_reg <= cmd_in;
      end
    end
  end

  wire [31:0] status_word = {23'h0, done_reg, 1'b0, pass_reg[3], pass_reg[2],
                             pass_reg[1], pass_reg[0], step_reg};
  wire [31:0] rd_mux = (bus_req.addr == DTSC_PARAMS_OFS) ? params_reg
                     : (bus_req.addr == DTSC_CMD_OFS)    ? {cmd_reg[31:19], 1'b0, cmd_reg[17:0]}
                     : (bus_req.addr == DTSC_STATUS_OFS) ? status_word
                     : 32'h0;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0;
    end else if (bus_req.rd) begin
      rdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------
  // module reset sequence
  // ----------------------------------------
  dtsc_rst_state_t rs_next;
  always_comb begin
    case (rs_reg)
      DTSC_RS_IDLE: rs_next = rst_cmd ? DTSC_RS_RST : DTSC_RS_IDLE;
      DTSC_RS_RST:  rs_next = rst_cmd ? DTSC_RS_RST : (rst_tmo ? DTSC_RS_CKE : DTSC_RS_RST);
      DTSC_RS_CKE:  rs_next = rst_cmd ? DTSC_RS_RST : (rst_tmo ? DTSC_RS_IDLE : DTSC_RS_CKE);
      default:      rs_next = DTSC_RS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rs_reg       <= DTSC_RS_IDLE;
      rstn_out_reg <= 1'b1;
      cke_reg      <= 1'b0;
    end else begin
      rs_reg       <= rs_next;
      rstn_out_reg <= (rs_next != DTSC_RS_RST);
      cke_reg      <= (rs_next == DTSC_RS_IDLE) && (cke_reg || rs_reg == DTSC_RS_CKE);
    end
  end

  // ----------------------------------------
  // outputs; control-word handling only for registered modules
  // ----------------------------------------
  wire regd = params_reg[DTSC_REGDIMM_BIT];
  assign bus_rdata      = rdata_reg;
  assign phy_step       = step_reg;
  assign step_start     = start_reg;
  assign mrs_go         = mrs_request;
  assign module_reset_n = rstn_out_reg;
  assign cke_allowed    = cke_reg;
  assign phy_cfg.rank            = cmd_reg[DTSC_RANK_LO +: 3];
  assign phy_cfg.regdimm         = regd;
  assign phy_cfg.use_three_cycle = regd && !params_reg[DTSC_SKIP3T_BIT];
  assign phy_cfg.use_inversion   = regd && !params_reg[DTSC_SKIPAI_BIT];
  assign phy_cfg.wl_gap  = params_reg[DTSC_WLGAP_BIT] ? DTSC_WL_GAP_LONG : DTSC_WL_GAP_SHORT;
  assign phy_cfg.ws_gap  = params_reg[DTSC_WSGAP_LO +: 5];
endmodule : dtsc_ctrl
`default_nettype wire

/* core/dtsc_pow2_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module dtsc_pow2_timer
  import dtsc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       load,
  input  wire logic [4:0] exp_n,
  output logic            expired
);
  logic [31:0] cnt_reg;
  logic        run_reg;
  wire  [31:0] load_val = 32'h1 << exp_n;

  // ----------------------------------------
  // counts 2^n cycles, pulses expired once
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 32'h0;
      run_reg <= 1'b0;
    end else if (load) begin
      cnt_reg <= load_val - 32'h1;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 32'h1;
      run_reg <= (cnt_reg != 32'h0);
    end
  end

  assign expired = run_reg && (cnt_reg == 32'h0);
endmodule : dtsc_pow2_timer
`default_nettype wire

/* tb/dtsc_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module dtsc_ctrl_asserts
  import dtsc_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          rstn,
  input wire dtsc_bus_req_t bus_req,
  input wire logic [31:0]   bus_rdata,
  input wire logic          step_pass,
  input wire logic          step_done,
  input wire logic          mrs_request,
  input wire dtsc_step_t    phy_step,
  input wire dtsc_phy_cfg_t phy_cfg,
  input wire logic          step_start,
  input wire logic          mrs_go,
  input wire logic          module_reset_n,
  input wire logic          cke_allowed
);
  // ----
  // helpers
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire w_cmd = bus_req.wr && bus_req.addr == DTSC_CMD_OFS;
  wire w_par = bus_req.wr && bus_req.addr == DTSC_PARAMS_OFS;
  logic [4:0]  rx_reg;
  logic [4:0]  cx_reg;
  logic        man_reg;
  logic [31:0] lo_reg;
  logic [31:0] hi_reg;
  // exponents shadowed here: widths are too long to unroll
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_reg <= 5'h0;
      cx_reg <= 5'h0;
      man_reg <= 1'b0;
      lo_reg <= 32'h0;
      hi_reg <= 32'h0;
    end else begin
      if (w_par) rx_reg <= bus_req.wdata[4:0];
      if (w_par) cx_reg <= bus_req.wdata[9:5];
      if (w_cmd) man_reg <= bus_req.wdata[1];
      lo_reg <= module_reset_n ? 32'h0 : lo_reg + 32'h1;
      hi_reg <= (module_reset_n && !cke_allowed) ? hi_reg + 32'h1 : 32'h0;
    end
  end
  sequence s_enter; $changed(phy_step) && phy_step != DTSC_ST_IDLE; endsequence
  sequence s_rstcmd; w_cmd && bus_req.wdata[DTSC_RESET_CMD_BIT]; endsequence
  property p_rank; w_cmd |=> phy_cfg.rank == $past(bus_req.wdata[7:5]); endproperty
  a_rank: assert property (p_rank) else $error("rank wrong");
  property p_wl; w_par |=> phy_cfg.wl_gap == ($past(bus_req.wdata[16]) ? 6'h20 : 6'h10); endproperty
  a_wl: assert property (p_wl) else $error("wl gap wrong");
  property p_ws; w_par |=> phy_cfg.ws_gap == $past(bus_req.wdata[21:17]); endproperty
  a_ws: assert property (p_ws) else $error("ws gap wrong");
  property p_cw;
    w_par |=> phy_cfg.regdimm == $past(bus_req.wdata[15])
      && phy_cfg.use_three_cycle == $past(bus_req.wdata[15] && !bus_req.wdata[26])
      && phy_cfg.use_inversion == $past(bus_req.wdata[15] && !bus_req.wdata[25]);
  endproperty
  a_cw: assert property (p_cw) else $error("control word cfg wrong");
  property p_start; s_enter |-> step_start; endproperty
  a_start: assert property (p_start) else $error("no step start");
  property p_order; (!man_reg and s_enter) |-> phy_step > $past(phy_step); endproperty
  a_order: assert property (p_order) else $error("step order wrong");
  property p_man; man_reg && $changed(phy_step) |-> $past(w_cmd); endproperty
  a_man: assert property (p_man) else $error("manual step moved");
  property p_rgo; s_rstcmd |=> !module_reset_n && !cke_allowed; endproperty
  a_rgo: assert property (p_rgo) else $error("reset not started");
  property p_rw; $rose(module_reset_n) |-> lo_reg == 32'h1 << rx_reg; endproperty
  a_rw: assert property (p_rw) else $error("reset width wrong");
  property p_ck; $rose(cke_allowed) |-> hi_reg == 32'h1 << cx_reg; endproperty
  a_ck: assert property (p_ck) else $error("cke hold wrong");
endmodule : dtsc_ctrl_asserts
`default_nettype wire

/* tb/dtsc_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dtsc_ctrl_tb_top import dtsc_pkg::*;;
  // ----
  // bench
  // ----
  logic          sys_clk = 1'b0;
  logic          rstn;
  dtsc_bus_req_t bus_req;
  dtsc_step_t    phy_step;
  dtsc_phy_cfg_t phy_cfg;
  logic [31:0]   bus_rdata, seed, p, c;
  logic          step_pass, step_done, mrs_request, step_start, mrs_go;
  logic          module_reset_n, cke_allowed, mute, rd_q;
  logic [3:0]    dly;
  int            fails, checked, cyc;
  logic [31:0]   exp_rd[$];
  dtsc_step_t    exp_step[$];
  always #50 sys_clk = ~sys_clk;
  dtsc_ctrl dtsc_ctrl_i(.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .step_pass(step_pass), .step_done(step_done), .mrs_request(mrs_request), .phy_step(phy_step),
    .phy_cfg(phy_cfg), .step_start(step_start), .mrs_go(mrs_go), .module_reset_n(module_reset_n),
    .cke_allowed(cke_allowed));
  dtsc_phy_model dtsc_phy_model_i(.sys_clk(sys_clk), .rstn(rstn), .step_start(step_start),
    .mute(mute), .dly(dly), .step_done(step_done), .step_pass(step_pass));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  // pushes codes 1..n except sk, launches, waits for idle or at most 400 cycles
  task automatic training_launch(input logic [31:0] cm, input logic [31:0] st, input int n, input int sk);
    for (int k = 1; k <= n; k++) if (k != sk) exp_step.push_back(dtsc_step_t'(k));
    wr(DTSC_CMD_OFS, cm);
    for (int i = 0; i < 400 && phy_step !== DTSC_ST_IDLE; i++) @(posedge sys_clk);
    rd(DTSC_STATUS_OFS, st);
  endtask : training_launch
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    seed <= lfsr(seed);
    mrs_request <= seed[3];
    // responder delay kept below the 16-cycle step timeout so every step passes
    dly <= {1'b0, seed[6:4]};
    rd_q <= bus_req.rd;
    chk({31'h0, mrs_go}, {31'h0, mrs_request}, "mrs_go");
    if (rd_q) chk(bus_rdata, exp_rd.pop_front(), "bus_rdata");
    if (step_start) chk(phy_step, exp_step.pop_front(), "phy_step");
    if (cyc == 4000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    rstn = 1'b0;
    bus_req = '0;
    mrs_request = 1'b0;
    mute = 1'b0;
    dly = 4'h0;
    seed = 32'h0001_2FD5;
    rd_q = 1'b0;
    fails = 0;
    checked = 0;
    cyc = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd(DTSC_PARAMS_OFS, DTSC_PARAMS_RST);
    rd(8'h40, 32'h0);
    p = {5'h0, seed[1:0], 3'h1, seed[8:4], 2'h3, 15'h1062};
    wr(DTSC_PARAMS_OFS, p);
    rd(DTSC_PARAMS_OFS, p);
    for (int k = 0; k < 2; k++) begin
      c = {24'h0, seed[2:0], 5'h01};
      training_launch(c, 32'h178, 4, 0);
      rd(DTSC_CMD_OFS, c & 32'hFFFF_FFFE);
    end
    training_launch(32'h2001, 32'h158, 4, 3);
    mute <= 1'b1;
    training_launch(32'h0301, 32'h100, 4, 0);
    training_launch(32'h0101, 32'h101, 1, 0);
    mute <= 1'b0;
    exp_step.push_back(DTSC_ST_WRLVL);
    wr(DTSC_CMD_OFS, 32'h0E);
    repeat (40) @(posedge sys_clk);
    wr(DTSC_CMD_OFS, 32'h02);
    wr(DTSC_CMD_OFS, 32'h0004_0000);
    for (int i = 0; i < 200 && cke_allowed !== 1'b1; i++) @(posedge sys_clk);
    chk({31'h0, cke_allowed & module_reset_n}, 32'h1, "cke_allowed");
    test_done();
  end
endmodule : dtsc_ctrl_tb_top
bind dtsc_ctrl dtsc_ctrl_asserts dtsc_ctrl_asserts_i(.sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .step_pass(step_pass), .step_done(step_done), .mrs_request(mrs_request),
  .phy_step(phy_step), .phy_cfg(phy_cfg), .step_start(step_start), .mrs_go(mrs_go),
  .module_reset_n(module_reset_n), .cke_allowed(cke_allowed));
`default_nettype wire

/* tb/dtsc_phy_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dtsc_phy_model
  import dtsc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       step_start,
  input  wire logic       mute,
  input  wire logic [3:0] dly,
  output logic            step_done,
  output logic            step_pass
);
  // ----
  // step responder
  // ----
  logic [4:0] cnt_reg;
  // muted: never answers, so only the step timer ends a step
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 5'h0;
      step_done <= 1'b0;
      step_pass <= 1'b0;
    end else begin
      step_done <= cnt_reg == 5'h1;
      step_pass <= (cnt_reg == 5'h1) ? 1'b1 : ~step_pass;
      if (step_start && !mute) cnt_reg <= {1'b0, dly} + 5'h2;
      else if (cnt_reg != 5'h0) cnt_reg <= cnt_reg - 5'h1;
    end
  end
endmodule : dtsc_phy_model
`default_nettype wire
